// ### include/ssrf_pkg.sv
// Constants, types and carriers of the speed reference soft start path
`default_nettype none
package ssrf_pkg;
   localparam int SSRF_VREF_W      = 15;
   localparam int SSRF_SPD_W       = 16;
   localparam int SSRF_FRAC_W      = 16;
   localparam int SSRF_ACC_W       = SSRF_SPD_W + SSRF_FRAC_W + 2;
   localparam int SSRF_TIME_W      = 14;
   localparam int SSRF_GAIN_W      = 12;
   localparam int SSRF_OFS_W       = 12;
   localparam int SSRF_CLK_MHZ     = 200;
   localparam int SSRF_SAMPLE_US   = 1000;
   localparam int SSRF_SAMPLE_CYC  = SSRF_SAMPLE_US * SSRF_CLK_MHZ;
   localparam int SSRF_AVG_LOG2    = 4;
   localparam logic [3:0]  SSRF_MODE_SPEED_ANALOG = 4'h0;
   localparam logic [SSRF_GAIN_W-1:0] SSRF_GAIN_MAX = 12'hBB8;
   localparam logic [SSRF_GAIN_W-1:0] SSRF_GAIN_DEF = 12'h096;
   localparam logic [SSRF_TIME_W-1:0] SSRF_TIME_MAX = 14'h2710;
   localparam logic [SSRF_TIME_W-1:0] SSRF_TIME_DEF = 14'h0000;
   localparam logic signed [SSRF_OFS_W-1:0] SSRF_OFS_MAX = 12'h400;
   localparam logic signed [SSRF_OFS_W-1:0] SSRF_OFS_MIN = -12'sh400;
   localparam logic signed [SSRF_OFS_W-1:0] SSRF_OFS_RST = 12'h000;
   localparam logic [SSRF_ACC_W-1:0] SSRF_MV_PER_V  = 34'h0000003E8;
   localparam logic [SSRF_ACC_W-1:0] SSRF_RPM_REF_Q = 34'h003E80000;
   localparam logic [SSRF_ACC_W-1:0] SSRF_STEP_MAX  = 34'h1FFFFFFFF;
   localparam logic [1:0] SSRF_SHAPE_DEF = 2'h0;

   typedef enum logic [1:0] {
      SSRF_RAMP,
      SSRF_SCURVE,
      SSRF_FILT1,
      SSRF_FILT2
   } ssrf_curve_e;

   typedef enum logic {
      SSRF_OFS_IDLE,
      SSRF_OFS_MEAS
   } ssrf_ofs_e;

   typedef struct packed {
      logic [SSRF_GAIN_W-1:0] gain;
      logic [SSRF_TIME_W-1:0] accel;
      logic [SSRF_TIME_W-1:0] decel;
      logic [SSRF_TIME_W-1:0] s_rise;
      logic [SSRF_TIME_W-1:0] tau;
   } ssrf_cfg_s;
endpackage
`default_nettype wire

// ### rtl/ssrf_lowpass.sv
// First-order delay stage updated once per sample tick
`timescale 1ns/100ps
`default_nettype none
module ssrf_lowpass #(
   parameter int W = 34
) (
   input  wire logic                clock,
   input  wire logic                nrst,
   input  wire logic                en,
   input  wire logic signed [W-1:0] x,
   input  wire logic        [14:0]  div,
   output var  logic signed [W-1:0] y_reg
);
   wire logic signed [W-1:0] err  = x - y_reg;
   wire logic signed [W-1:0] divs = W'(signed'({1'b0, div}));
   wire logic signed [W-1:0] step = err / divs;
   // Divisor of one makes the stage a plain pass-through
   // Truncated steps stall a few LSBs short of a steady input, so the last one is taken whole
   wire logic signed [W-1:0] y_next = (step == '0) ? x : y_reg + step;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         y_reg <= '0;
      end else if (en) begin
         y_reg <= y_next;
      end
   end
endmodule
`default_nettype wire

// ### rtl/ssrf_soft_start.sv
// Analog speed reference scaling, offset trim and soft start shaping
// How it works
// - The path drives a speed command only when the mode sampled at restart is 0.
// - The target speed is the reference voltage times the gain, sign giving direction.
// - Gain is clamped to 0..3000 rpm/V, resets to 150 and applies on the write.
// - Auto trim averages the reference at 0 V and subtracts the stored result.
// - The trim value lives apart from the settings and only the trim utilities change it.
// - A manually entered trim is clamped to -1024..1024.
// - Curve form picks ramp, S-curve, one or two filter stages, sampled at restart.
// - Ramp acceleration slope covers 1000 rpm in the accel time.
// - Ramp deceleration slope covers 1000 rpm in the decel time.
// - Accel time is clamped to 0..10000 ms, resets to 0, applies on the write.
// - Decel time is clamped to 0..10000 ms, resets to 0, applies on the write.
// - S-curve rise time sets the rise from standstill to target, 0..10000 ms, default 0; a fall steps by the new target over it, one LSB toward 0.
// - S shape 0..3 picks the corner smoothing and is sampled at restart.
// - Filter forms use a first-order delay with a 0..10000 ms time constant.
`timescale 1ns/100ps
`default_nettype none
module ssrf_soft_start
   import ssrf_pkg::*;
#(
   parameter int SAMPLE_CYCLES = ssrf_pkg::SSRF_SAMPLE_CYC
) (
   input  wire logic                                     clock,
   input  wire logic                                     nrst,
   input  wire logic signed [ssrf_pkg::SSRF_VREF_W-1:0]  vref_mv,
   input  wire logic [3:0]                               control_mode_select,
   input  wire logic [1:0]                               curve_form_select,
   input  wire logic [1:0]                               s_shape_select,
   input  wire logic                                     cfg_wr,
   input  wire ssrf_pkg::ssrf_cfg_s                      cfg_in,
   input  wire logic                                     auto_offset_utility,
   input  wire logic                                     manual_offset_utility,
   input  wire logic signed [ssrf_pkg::SSRF_OFS_W-1:0]   manual_offset_value,
   output var  logic signed [ssrf_pkg::SSRF_SPD_W-1:0]   speed_cmd_reg,
   output var  logic                                     speed_mode_reg,
   output var  logic signed [ssrf_pkg::SSRF_OFS_W-1:0]   offset_reg,
   output var  logic                                     offset_busy_reg,
   output var  ssrf_pkg::ssrf_cfg_s                      cfg_reg
);
   import ssrf_pkg::*;

   localparam int AW = SSRF_ACC_W;

   function automatic logic [SSRF_TIME_W-1:0] clamp_t(input logic [SSRF_TIME_W-1:0] v);
      clamp_t = (v > SSRF_TIME_MAX) ? SSRF_TIME_MAX : v;
   endfunction

   function automatic logic signed [SSRF_OFS_W-1:0] clamp_o(input logic signed [AW-1:0] v);
      if (v > AW'(SSRF_OFS_MAX)) begin
         clamp_o = SSRF_OFS_MAX;
      end else if (v < AW'(SSRF_OFS_MIN)) begin
         clamp_o = SSRF_OFS_MIN;
      end else begin
         clamp_o = v[SSRF_OFS_W-1:0];
      end
   endfunction

   function automatic logic [AW-1:0] mag(input logic signed [AW-1:0] v);
      mag = v[AW-1] ? AW'(-v) : v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Sample tick and restart-time settings

   logic [17:0]        tick_cnt_reg;
   logic               tick_reg;
   logic               boot_reg;
   ssrf_curve_e        curve_reg;
   logic [1:0]         shape_reg;

   wire logic tick_wrap = (tick_cnt_reg == 18'(SAMPLE_CYCLES - 1));

   always_ff @(posedge clock) begin
      if (!nrst) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end else begin
         tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + 18'h00001;
         tick_reg     <= tick_wrap;
      end
   end

   // Caught on the first edge after release so a live change waits for restart
   always_ff @(posedge clock) begin
      if (!nrst) begin
         boot_reg       <= 1'b0;
         curve_reg      <= SSRF_RAMP;
         shape_reg      <= SSRF_SHAPE_DEF;
         speed_mode_reg <= 1'b0;
      end else if (!boot_reg) begin
         boot_reg       <= 1'b1;
         curve_reg      <= ssrf_curve_e'(curve_form_select);
         shape_reg      <= s_shape_select;
         speed_mode_reg <= (control_mode_select == SSRF_MODE_SPEED_ANALOG);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Immediate settings

   ssrf_cfg_s cfg_next;
   always_comb begin
      cfg_next        = cfg_in;
      cfg_next.gain   = (cfg_in.gain > SSRF_GAIN_MAX) ? SSRF_GAIN_MAX : cfg_in.gain;
      cfg_next.accel  = clamp_t(cfg_in.accel);
      cfg_next.decel  = clamp_t(cfg_in.decel);
      cfg_next.s_rise = clamp_t(cfg_in.s_rise);
      cfg_next.tau    = clamp_t(cfg_in.tau);
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         cfg_reg <= '{SSRF_GAIN_DEF, SSRF_TIME_DEF, SSRF_TIME_DEF, SSRF_TIME_DEF,
                      SSRF_TIME_DEF};
      end else if (cfg_wr) begin
         cfg_reg <= cfg_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Offset trim

   ssrf_ofs_e                ofs_st_reg;
   logic [SSRF_AVG_LOG2-1:0] ofs_cnt_reg;
   logic signed [AW-1:0]     ofs_sum_reg;

   wire logic signed [AW-1:0] vref_ext = AW'(vref_mv);
   wire logic signed [AW-1:0] ofs_sum_next = ofs_sum_reg + vref_ext;
   wire logic                 ofs_last = &ofs_cnt_reg;

   // Trim has no path from the setting writes, so restoring settings keeps it
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ofs_st_reg      <= SSRF_OFS_IDLE;
         ofs_cnt_reg     <= '0;
         ofs_sum_reg     <= '0;
         offset_reg      <= SSRF_OFS_RST;
         offset_busy_reg <= 1'b0;
      end else begin
         case (ofs_st_reg)
            SSRF_OFS_IDLE: begin
               ofs_cnt_reg <= '0;
               ofs_sum_reg <= '0;
               if (auto_offset_utility) begin
                  ofs_st_reg      <= SSRF_OFS_MEAS;
                  offset_busy_reg <= 1'b1;
               end else if (manual_offset_utility) begin
                  offset_reg <= clamp_o(AW'(manual_offset_value));
               end
            end
            SSRF_OFS_MEAS: begin
               if (tick_reg) begin
                  ofs_sum_reg <= ofs_sum_next;
                  ofs_cnt_reg <= ofs_cnt_reg + 1'b1;
                  if (ofs_last) begin
                     offset_reg      <= clamp_o(ofs_sum_next >>> SSRF_AVG_LOG2);
                     ofs_st_reg      <= SSRF_OFS_IDLE;
                     offset_busy_reg <= 1'b0;
                  end
               end
            end
            default: begin
               ofs_st_reg      <= SSRF_OFS_IDLE;
               offset_busy_reg <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Target speed in rpm, Q16 fraction

   wire logic signed [AW-1:0] corr_mv = vref_ext - AW'(offset_reg);
   wire logic signed [AW-1:0] gain_s  = AW'(signed'({1'b0, cfg_reg.gain}));
   wire logic signed [AW-1:0] rpm     = (corr_mv * gain_s) / signed'(SSRF_MV_PER_V);
   wire logic signed [AW-1:0] tgt_q   = rpm <<< SSRF_FRAC_W;

   ////////////////////////////////////////////////////////////////////////////
   // Ramp, shared by ramp form and the linear part of the S-curve

   logic signed [AW-1:0] ramp_reg;

   wire logic [AW-1:0] tgt_mag  = mag(tgt_q);
   wire logic [AW-1:0] cur_mag  = mag(ramp_reg);
   wire logic          same_dir = (tgt_q[AW-1] == ramp_reg[AW-1]);
   wire logic          speeding = (ramp_reg == '0) || (same_dir && (tgt_mag > cur_mag));
   wire logic [SSRF_TIME_W-1:0] ramp_t = speeding ? cfg_reg.accel : cfg_reg.decel;
   wire logic [AW-1:0] lin_step = SSRF_RPM_REF_Q / AW'(ramp_t);
   wire logic [AW-1:0] s_step   = tgt_mag / AW'(cfg_reg.s_rise);
   wire logic          scurve   = (curve_reg == SSRF_SCURVE);
   wire logic [SSRF_TIME_W-1:0] use_t = scurve ? cfg_reg.s_rise : ramp_t;
   // Zero time would divide by zero; it jumps straight to target instead
   wire logic [AW-1:0] step = (use_t == '0) ? SSRF_STEP_MAX :
                              (scurve ? ((s_step == '0) ? AW'(1) : s_step) : lin_step);
   wire logic signed [AW-1:0] diff   = tgt_q - ramp_reg;
   wire logic signed [AW-1:0] ramp_next =
      (mag(diff) <= step) ? tgt_q :
      (diff[AW-1] ? ramp_reg - signed'(step) : ramp_reg + signed'(step));

   always_ff @(posedge clock) begin
      if (!nrst) begin
         ramp_reg <= '0;
      end else if (tick_reg) begin
         ramp_reg <= ramp_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Delay stages: S-curve corner rounding or the reference filter

   logic signed [AW-1:0] stg1_y;
   logic signed [AW-1:0] stg2_y;

   // Rounding takes a fraction of the rise time, so the curve ends a little late
   wire logic [SSRF_TIME_W-1:0] round_t = cfg_reg.s_rise >> (3'(shape_reg) + 3'h2);
   wire logic [14:0] div1 = scurve ? ({1'b0, round_t} + 15'h0001)
                                   : ({1'b0, cfg_reg.tau} + 15'h0001);
   wire logic [14:0] div2 = {1'b0, cfg_reg.tau} + 15'h0001;
   wire logic signed [AW-1:0] stg1_x = scurve ? ramp_reg : tgt_q;

   ssrf_lowpass #(.W(AW)) u_stage1 (
      .clock (clock),
      .nrst  (nrst),
      .en    (tick_reg),
      .x     (stg1_x),
      .div   (div1),
      .y_reg (stg1_y)
   );

   ssrf_lowpass #(.W(AW)) u_stage2 (
      .clock (clock),
      .nrst  (nrst),
      .en    (tick_reg),
      .x     (stg1_y),
      .div   (div2),
      .y_reg (stg2_y)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Output select and saturation

   wire logic signed [AW-1:0] shaped =
      (curve_reg == SSRF_RAMP)  ? ramp_reg :
      (curve_reg == SSRF_FILT2) ? stg2_y : stg1_y;
   wire logic signed [AW-1:0] shaped_rpm = shaped >>> SSRF_FRAC_W;
   wire logic signed [SSRF_SPD_W-1:0] sat_rpm =
      (shaped_rpm > AW'(16'sh7FFF))  ? 16'sh7FFF :
      (shaped_rpm < -AW'(16'sh7FFF)) ? -16'sh7FFF : shaped_rpm[SSRF_SPD_W-1:0];

   always_ff @(posedge clock) begin
      if (!nrst) begin
         speed_cmd_reg <= '0;
      end else if (tick_reg) begin
         speed_cmd_reg <= speed_mode_reg ? sat_rpm : '0;
      end
   end
endmodule
`default_nettype wire

// ### verif/ssrf_host_model.sv
// Host controller model driving the analog speed reference
`timescale 1ns/100ps
`default_nettype none
module ssrf_host_model (
   input  wire logic               clock,
   input  wire logic signed [14:0] level,
   input  wire logic               slow,
   output var  logic signed [14:0] vref_mv
);
   int d;
   initial vref_mv = 15'sh0;
   // Slow mode slews 250 mV a clock, like an output stage with limited slew rate
   always @(negedge clock) begin
      d = int'(level) - int'(vref_mv);
      if (!slow || (d < 250 && d > -250)) vref_mv <= level;
      else vref_mv <= vref_mv + ((d > 0) ? 15'sh0FA : -15'sh0FA);
   end
endmodule
`default_nettype wire

// ### verif/ssrf_soft_start_asserts.sv
// Port checker of the soft start path and its bind
`timescale 1ns/100ps
`default_nettype none
module ssrf_checker #(
   parameter int SAMPLE_CYCLES = 20
) (
   input  wire logic               clock,
   input  wire logic               nrst,
   input  wire logic               cfg_wr,
   input  wire ssrf_pkg::ssrf_cfg_s cfg_in,
   input  wire logic               auto_offset_utility,
   input  wire logic               manual_offset_utility,
   input  wire logic signed [11:0] manual_offset_value,
   input  wire logic signed [15:0] speed_cmd_reg,
   input  wire logic               speed_mode_reg,
   input  wire logic signed [11:0] offset_reg,
   input  wire logic               offset_busy_reg,
   input  wire ssrf_pkg::ssrf_cfg_s cfg_reg
);
   import ssrf_pkg::*;
   // Trim takes 16 ticks plus up to one tick of phase
   localparam int BUSY_MAX = 17 * SAMPLE_CYCLES + 4;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   function automatic logic [13:0] ct(input logic [13:0] t);
      return (t > SSRF_TIME_MAX) ? SSRF_TIME_MAX : t;
   endfunction
   function automatic logic signed [11:0] co(input logic signed [11:0] v);
      return (v > SSRF_OFS_MAX) ? SSRF_OFS_MAX : ((v < SSRF_OFS_MIN) ? SSRF_OFS_MIN : v);
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   gain_clamp_a: assert property (cfg_wr |=> cfg_reg.gain ==
      (($past(cfg_in.gain) > SSRF_GAIN_MAX) ? SSRF_GAIN_MAX : $past(cfg_in.gain)))
      else $error("gain clamp");
   accel_clamp_a: assert property (cfg_wr |=> cfg_reg.accel == ct($past(cfg_in.accel)))
      else $error("accel clamp");
   decel_clamp_a: assert property (cfg_wr |=> cfg_reg.decel == ct($past(cfg_in.decel)))
      else $error("decel clamp");
   rise_clamp_a: assert property (cfg_wr |=> cfg_reg.s_rise == ct($past(cfg_in.s_rise)))
      else $error("rise clamp");
   tau_clamp_a: assert property (cfg_wr |=> cfg_reg.tau == ct($past(cfg_in.tau)))
      else $error("tau clamp");
   reset_value_a: assert property ($rose(nrst) |-> cfg_reg == {SSRF_GAIN_DEF, 56'h0}
      && offset_reg == 12'h000 && speed_cmd_reg == 16'h0000 && !offset_busy_reg)
      else $error("reset values");
   manual_trim_a: assert property (manual_offset_utility && !auto_offset_utility
      && !offset_busy_reg |=> offset_reg == co($past(manual_offset_value)))
      else $error("manual trim");
   auto_busy_a: assert property (auto_offset_utility && !offset_busy_reg
      |=> offset_busy_reg ##[1:BUSY_MAX] !offset_busy_reg) else $error("auto trim");
   trim_hold_a: assert property (!manual_offset_utility && !auto_offset_utility
      && !offset_busy_reg |=> $stable(offset_reg)) else $error("trim hold");
   mode_gate_a: assert property (!speed_mode_reg |-> speed_cmd_reg == 16'h0000)
      else $error("mode gate");
endmodule
bind ssrf_soft_start ssrf_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk (.clock(clock),
   .nrst(nrst), .cfg_wr(cfg_wr), .cfg_in(cfg_in), .auto_offset_utility(auto_offset_utility),
   .manual_offset_utility(manual_offset_utility), .manual_offset_value(manual_offset_value),
   .speed_cmd_reg(speed_cmd_reg), .speed_mode_reg(speed_mode_reg), .offset_reg(offset_reg),
   .offset_busy_reg(offset_busy_reg), .cfg_reg(cfg_reg));
`default_nettype wire

// ### verif/ssrf_soft_start_test.sv
// Self-checking bench of the speed reference soft start path
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end
module ssrf_soft_start_test;
   import ssrf_pkg::*;
   localparam int TK = 20;
   logic clock = 1'b0, nrst = 1'b0, slow = 1'b0, cfg_wr = 1'b0;
   logic auto_offset_utility = 1'b0, manual_offset_utility = 1'b0, speed_mode_reg;
   logic offset_busy_reg;
   logic signed [14:0] level = 15'sh0, vref_mv;
   logic [3:0] control_mode_select = 4'h0;
   logic [1:0] curve_form_select = 2'h0, s_shape_select = 2'h0;
   logic signed [11:0] manual_offset_value = 12'sh0, offset_reg;
   logic signed [15:0] speed_cmd_reg;
   ssrf_cfg_s cfg_in = '0, cfg_reg;
   logic [31:0] seed = 32'h40E9B200;
   int err_count = 0, total_checks = 0, i, f, v, g, ofs;
   always #2.5 clock = ~clock;
   ssrf_host_model host (.clock(clock), .level(level), .slow(slow), .vref_mv(vref_mv));
   ssrf_soft_start #(.SAMPLE_CYCLES(TK)) dut (.clock(clock), .nrst(nrst), .vref_mv(vref_mv),
      .control_mode_select(control_mode_select), .curve_form_select(curve_form_select),
      .s_shape_select(s_shape_select), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
      .auto_offset_utility(auto_offset_utility), .manual_offset_utility(manual_offset_utility),
      .manual_offset_value(manual_offset_value), .speed_cmd_reg(speed_cmd_reg),
      .speed_mode_reg(speed_mode_reg), .offset_reg(offset_reg),
      .offset_busy_reg(offset_busy_reg), .cfg_reg(cfg_reg));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Truncates toward zero, then saturates to the command width
   function automatic logic signed [15:0] exp_spd(input int v, input int o, input int g);
      int s;
      s = (v - o) * g / 1000;
      s = (s > 32767) ? 32767 : ((s < -32767) ? -32767 : s);
      return s[15:0];
   endfunction
   task automatic results();
      if (err_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic restart(input logic [3:0] m, input logic [1:0] c);
      nrst = 1'b0;
      control_mode_select = m;
      curve_form_select = c;
      s_shape_select = 2'(rnd());
      repeat (12) @(negedge clock);
      nrst = 1'b1;
      repeat (2) @(negedge clock);
   endtask
   task automatic wcfg(input logic [11:0] g, input logic [13:0] a, d, t);
      cfg_wr = 1'b1;
      cfg_in = '{g, a, d, t, t};
      @(negedge clock);
      cfg_wr = 1'b0;
      @(negedge clock);
   endtask
   task automatic pulse(input logic a, m, input logic signed [11:0] mv);
      auto_offset_utility = a;
      manual_offset_utility = m;
      manual_offset_value = mv;
      @(negedge clock);
      auto_offset_utility = 1'b0;
      manual_offset_utility = 1'b0;
      @(negedge clock);
   endtask
   task automatic wait_chg(input logic signed [15:0] old);
      for (i = 0; i < 200 && speed_cmd_reg === old; i++) @(negedge clock);
      if (i == 200) begin err_count++; results(); end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      restart(4'h0, 2'h0);
      `CHK(cfg_reg, {SSRF_GAIN_DEF, 56'h0})
      wcfg(12'hFFF, 14'h3FFF, 14'h2711, 14'h3FFF);
      `CHK(cfg_reg, {12'hBB8, {4{14'h2710}}})
      for (f = 0; f < 4; f++) wcfg(12'(rnd()), 14'(rnd()), 14'(rnd()), 14'(rnd()));
      pulse(1'b0, 1'b1, -12'sh5DC);
      `CHK(offset_reg, -12'sh400)
      pulse(1'b0, 1'b1, 12'sh400);
      `CHK(offset_reg, 12'sh400)
      for (f = 0; f < 3; f++) pulse(1'b0, 1'b1, 12'(rnd()));
      for (f = 0; f < 4; f++) begin
         restart(4'h0, 2'(f));
         level = -15'sd10000;
         repeat (4 * TK) @(negedge clock);
         `CHK(speed_cmd_reg, -16'sd1500)
      end
      // Shaped forms start gently and settle on the target
      for (f = 1; f < 4; f++) begin
         level = 15'sh0;
         restart(4'h0, 2'(f));
         wcfg(12'h3E8, 14'h0000, 14'h0000, 14'h0004);
         level = 15'sh0320;
         wait_chg(16'sh0000);
         `CHK(speed_cmd_reg > 16'sh0000 && speed_cmd_reg < 16'sh0320, 1'b1)
         repeat (120 * TK) @(negedge clock);
         `CHK(speed_cmd_reg, 16'sh0320)
      end
      restart(4'(rnd() % 15 + 1), 2'h0);
      level = 15'sd5000;
      repeat (4 * TK) @(negedge clock);
      `CHK({speed_mode_reg, speed_cmd_reg}, 17'h0)
      restart(4'h0, 2'h0);
      control_mode_select = 4'h2;
      repeat (4 * TK) @(negedge clock);
      `CHK(speed_cmd_reg, 16'sd750)
      level = 15'sh0;
      repeat (4 * TK) @(negedge clock);
      wcfg(12'h3E8, 14'h000A, 14'h0005, 14'h0000);
      level = 15'sd500;
      wait_chg(16'sh0);
      `CHK(speed_cmd_reg, 16'sd100)
      repeat (TK) @(negedge clock);
      `CHK(speed_cmd_reg, 16'sd200)
      repeat (6 * TK) @(negedge clock);
      `CHK(speed_cmd_reg, 16'sd500)
      level = 15'sh0;
      wait_chg(16'sd500);
      `CHK(speed_cmd_reg, 16'sd300)
      repeat (TK) @(negedge clock);
      `CHK(speed_cmd_reg, 16'sd100)
      ofs = int'(rnd() % 61) - 30;
      level = 15'(ofs);
      repeat (2) @(negedge clock);
      pulse(1'b1, 1'b1, 12'sh123);
      for (i = 0; i < 400 && offset_busy_reg !== 1'b0; i++) @(negedge clock);
      if (i == 400) begin err_count++; results(); end
      `CHK(offset_reg, 12'(ofs))
      for (f = 0; f < 12; f++) begin
         v = (f == 0) ? -10000 : int'(rnd() % 20001) - 10000;
         g = (f == 0) ? 3000 : ((f == 1) ? 0 : int'(rnd() % 3001));
         slow = 1'(rnd());
         level = 15'(v);
         wcfg(12'(g), 14'h0, 14'h0, 14'h0);
         repeat (8 * TK) @(negedge clock);
         `CHK(speed_cmd_reg, exp_spd(v, ofs, g))
      end
      results();
   end
endmodule
`default_nettype wire
